/* verilog/ssp_pkg.sv */
package ssp_pkg;
    localparam int          CLK_HZ         = 100_000_000;
    localparam int          WC_TIME_US     = 5000;
    localparam int          WC_CYCLES      = WC_TIME_US * (CLK_HZ / 1_000_000);
    localparam int          ADDR_W         = 15;
    localparam logic [3:0]  OP_UPPER_ZERO  = 4'h0;
    localparam logic [2:0]  OP_SET_LATCH   = 3'h6;
    localparam logic [2:0]  OP_CLEAR_LATCH = 3'h4;
    localparam logic [2:0]  OP_READ_STATUS = 3'h5;
    localparam logic [2:0]  OP_WRITE_STAT  = 3'h1;
    localparam logic [2:0]  OP_READ_ARRAY  = 3'h3;
    localparam logic [2:0]  OP_WRITE_ARRAY = 3'h2;
    localparam int          ST_GUARD_EN    = 7;
    localparam int          ST_LVL_HI      = 3;
    localparam int          ST_LVL_LO      = 2;
    localparam int          ST_LATCH       = 1;
    localparam int          ST_BUSY        = 0;
    localparam logic [2:0]  RESERVED_BUSY  = 3'h7;
    localparam logic [2:0]  RESERVED_IDLE  = 3'h0;
    localparam logic [1:0]  LVL_NONE       = 2'h0;
    localparam logic [1:0]  LVL_QUARTER    = 2'h1;
    localparam logic [1:0]  LVL_HALF       = 2'h2;
    localparam logic [1:0]  NV_RESET       = 2'h0;

    typedef enum logic [2:0] {
        SSP_IDLE   = 3'b000,
        SSP_OPCODE = 3'b001,
        SSP_RDSTAT = 3'b010,
        SSP_WRSTAT = 3'b011,
        SSP_ARRAY  = 3'b100,
        SSP_IGNORE = 3'b101
    } ssp_phase_t;

    typedef struct packed {
        logic              write_latch;
        logic              guard_pin_enable;
        logic [1:0]        block_level;
    } ssp_status_t;

    typedef struct packed {
        logic              write_req;
        logic [ADDR_W-1:0] addr;
    } ssp_array_req_t;
endpackage : ssp_pkg

/* verilog/ssp_core.sv */
// Operation
// [R1] guard pin high: only latch and levels decide
// [R2] guard low, enable set: refuse status writes
// [R3] guard fall aborts status write before cycle
// [R4] enable clear: guard pin ignored
// [R5] falling select starts command, msb first
// [R6] upper nibble zero, bit3 ignored, low decode
// [R7] status layout enable, reserved, level, latch, busy
// [R8] reserved bits ones only while busy
// [R9] busy flag high during internal cycle
// [R10] read status shifts value after opcode
// [R11] latch required before any write command
// [R12] set latch on select rise after opcode
// [R13] latch clear at power up
// [R14] clear latch opcode ignores guard pin
// [R15] status write changes bits 7,3,2 only
// [R16] enable and level bits held nonvolatile
// [R17] valid status write starts timed cycle
// [R18] during cycle only read status accepted
// [R19] cycle end clears latch
// [R20] level maps none, quarter, half, all
// [R21] enable clear: array by level, status by latch
// [R22] hardware guard blocks status and protected array; code blocks all array writes while guarded
// [R23] unknown opcode: ignore until next select
// [R24] write without latch discarded silently
module ssp_core
    import ssp_pkg::*;
#(
    parameter int          WC_COUNT = WC_CYCLES,
    parameter int          AW       = ADDR_W
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_resetn,
    input  wire logic                 i_cs_n,
    input  wire logic                 i_sck,
    input  wire logic                 i_si,
    input  wire logic                 i_guard_n,
    input  wire logic [1:0]           i_nv_bits_level,
    input  wire logic                 i_nv_bits_enable,
    output      logic                 o_so,
    output      logic                 o_so_oe,
    output      ssp_pkg::ssp_status_t o_status,
    output      logic                 o_busy,
    output      ssp_pkg::ssp_array_req_t o_array_req,
    output      logic                 o_array_allowed
);
    import ssp_pkg::*;

    typedef struct packed {
        logic [1:0]  cs_s;
        logic [1:0]  sck_s;
        logic [1:0]  si_s;
        logic [1:0]  gd_s;
        logic        cs_d;
        logic        sck_d;
        logic        gd_d;
        logic        loaded;
        ssp_phase_t  phase;
        logic [4:0]  bitcnt;
        logic [7:0]  shreg;
        logic [15:0] addr;
        logic [7:0]  data;
        logic [7:0]  txreg;
        logic        so;
        logic        so_oe;
        logic        pend_set;
        logic        pend_clr;
        logic        pend_wrs;
        logic        pend_arr;
        logic [7:0]  wrs_byte;
        ssp_status_t stat;
        logic        busy;
        logic [31:0] wc_cnt;
        ssp_array_req_t areq;
        logic        allowed;
    } ssp_state_t;

    ssp_state_t st;
    ssp_state_t next_st;

    logic        cs_low;
    logic        cs_fall;
    logic        cs_rise;
    logic        sck_rise;
    logic        sck_fall;
    logic        guard_low;
    logic        hw_guard;
    logic [7:0]  status_byte;
    logic [7:0]  next_shift;
    logic [AW-1:0] top_addr;
    logic        in_protect;

    function automatic logic addr_protected(input logic [1:0] lvl, input logic [AW-1:0] a);
        logic p;
        p = 1'b0;
        case (lvl)
            LVL_NONE:    p = 1'b0;
            LVL_QUARTER: p = (a[AW-1:AW-2] == 2'h3);
            LVL_HALF:    p = a[AW-1];
            default:     p = 1'b1;
        endcase
        return p;
    endfunction : addr_protected

    always_comb begin
        cs_low      = ~st.cs_s[1];
        cs_fall     = st.cs_d & ~st.cs_s[1];
        cs_rise     = ~st.cs_d & st.cs_s[1];
        sck_rise    = ~st.sck_d & st.sck_s[1];
        sck_fall    = st.sck_d & ~st.sck_s[1];
        guard_low   = ~st.gd_s[1];
        hw_guard    = guard_low & st.stat.guard_pin_enable; // [R1] [R4]
        status_byte = {st.stat.guard_pin_enable,
                       st.busy ? RESERVED_BUSY : RESERVED_IDLE, // [R8]
                       st.stat.block_level,
                       st.stat.write_latch,
                       st.busy}; // [R7] [R9]
        next_shift  = {st.shreg[6:0], st.si_s[1]}; // [R5]
        top_addr    = st.addr[AW-1:0];
        in_protect  = addr_protected(st.stat.block_level, top_addr); // [R20]
    end

    always_comb begin
        next_st          = st;
        next_st.cs_s     = {st.cs_s[0], i_cs_n};
        next_st.sck_s    = {st.sck_s[0], i_sck};
        next_st.si_s     = {st.si_s[0], i_si};
        next_st.gd_s     = {st.gd_s[0], i_guard_n};
        next_st.cs_d     = st.cs_s[1];
        next_st.sck_d    = st.sck_s[1];
        next_st.gd_d     = st.gd_s[1];
        next_st.areq.write_req = 1'b0;
        next_st.allowed  = ~in_protect & ~hw_guard;

        if (!st.loaded) begin
            next_st.loaded                = 1'b1;
            next_st.stat.block_level      = i_nv_bits_level; // [R16]
            next_st.stat.guard_pin_enable = i_nv_bits_enable; // [R16]
        end

        if (st.busy) begin
            if (st.wc_cnt >= 32'(WC_COUNT - 1)) begin
                next_st.busy             = 1'b0;
                next_st.stat.write_latch = 1'b0; // [R19]
                if (st.pend_wrs) begin
                    next_st.stat.guard_pin_enable = st.wrs_byte[ST_GUARD_EN]; // [R15]
                    next_st.stat.block_level      = st.wrs_byte[ST_LVL_HI:ST_LVL_LO]; // [R15]
                end
                next_st.pend_wrs = 1'b0;
            end else begin
                next_st.wc_cnt = st.wc_cnt + 32'h1;
            end
        end

        if (cs_fall) begin
            next_st.phase    = SSP_OPCODE; // [R5]
            next_st.bitcnt   = 5'h0;
            next_st.pend_set = 1'b0;
            next_st.pend_clr = 1'b0;
            next_st.pend_arr = 1'b0;
            if (!st.busy) begin
                next_st.pend_wrs = 1'b0;
            end
        end else if (cs_rise) begin
            next_st.phase = SSP_IDLE;
            next_st.so_oe = 1'b0;
            if (st.pend_set) begin
                next_st.stat.write_latch = 1'b1; // [R12]
            end
            if (st.pend_clr) begin
                next_st.stat.write_latch = 1'b0; // [R14]
            end
            if (st.pend_wrs && !st.busy) begin
                next_st.busy   = 1'b1; // [R17]
                next_st.wc_cnt = 32'h0;
            end
            if (st.pend_arr && !st.busy) begin
                next_st.areq.write_req = 1'b1;
                next_st.areq.addr      = top_addr;
            end
        end else if (cs_low) begin
            if (st.phase == SSP_WRSTAT && st.gd_d && guard_low && st.stat.guard_pin_enable) begin
                next_st.phase    = SSP_IGNORE; // [R3]
                next_st.pend_wrs = 1'b0; // [R3]
            end
            if (sck_rise && next_st.phase != SSP_IGNORE && st.phase != SSP_IDLE) begin
                next_st.shreg  = next_shift;
                next_st.bitcnt = st.bitcnt + 5'h1;
                case (st.phase)
                    SSP_OPCODE: begin
                        if (st.bitcnt == 5'h7) begin
                            next_st.bitcnt = 5'h0;
                            if (next_shift[7:4] != OP_UPPER_ZERO) begin
                                next_st.phase = SSP_IGNORE; // [R6] [R23]
                            end else if (next_shift[2:0] == OP_READ_STATUS) begin
                                next_st.phase = SSP_RDSTAT; // [R10] [R18]
                                next_st.txreg = status_byte;
                            end else if (st.busy) begin
                                next_st.phase = SSP_IGNORE; // [R18]
                            end else begin
                                case (next_shift[2:0])
                                    OP_SET_LATCH: begin
                                        next_st.pend_set = 1'b1;
                                        next_st.phase    = SSP_IGNORE;
                                    end
                                    OP_CLEAR_LATCH: begin
                                        next_st.pend_clr = 1'b1;
                                        next_st.phase    = SSP_IGNORE;
                                    end
                                    OP_WRITE_STAT: begin
                                        next_st.phase = (st.stat.write_latch && !hw_guard)
                                                        ? SSP_WRSTAT : SSP_IGNORE; // [R2] [R11] [R21] [R22] [R24]
                                    end
                                    OP_WRITE_ARRAY: begin
                                        next_st.phase = st.stat.write_latch
                                                        ? SSP_ARRAY : SSP_IGNORE; // [R11] [R24]
                                    end
                                    default: next_st.phase = SSP_IGNORE; // [R23]
                                endcase
                            end
                        end
                    end
                    SSP_WRSTAT: begin
                        if (st.bitcnt == 5'h7) begin
                            next_st.wrs_byte = next_shift;
                            next_st.pend_wrs = 1'b1;
                        end else if (st.bitcnt > 5'h7) begin
                            next_st.pend_wrs = 1'b0;
                            next_st.phase    = SSP_IGNORE;
                        end
                    end
                    SSP_ARRAY: begin
                        if (st.bitcnt < 5'h10) begin
                            next_st.addr = {st.addr[14:0], st.si_s[1]};
                        end else begin
                            next_st.data = next_shift;
                            if (st.bitcnt == 5'h17) begin
                                next_st.bitcnt   = 5'h10;
                                next_st.pend_arr = ~in_protect & ~hw_guard; // [R20] [R22]
                            end
                        end
                    end
                    default: next_st.bitcnt = st.bitcnt;
                endcase
            end
            if (sck_fall && st.phase == SSP_RDSTAT) begin
                next_st.so_oe = 1'b1;
                next_st.so    = st.txreg[7];
                next_st.txreg = {st.txreg[6:0], st.txreg[7]};
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st                  <= '0;
            st.cs_s             <= 2'h3;
            st.cs_d             <= 1'b1;
            st.gd_s             <= 2'h3;
            st.gd_d             <= 1'b1;
            st.phase            <= SSP_IDLE;
            st.stat.block_level <= NV_RESET;
            st.stat.write_latch <= 1'b0; // [R13]
        end else begin
            st <= next_st;
        end
    end

    assign o_so            = st.so;
    assign o_so_oe         = st.so_oe;
    assign o_status        = st.stat;
    assign o_busy          = st.busy;
    assign o_array_req     = st.areq;
    assign o_array_allowed = st.allowed;
endmodule : ssp_core

/* sim/ssp_core_checker.sv */
module ssp_core_checker
    import ssp_pkg::*;
#(
    parameter int WC_COUNT = WC_CYCLES
) (
    input wire logic            i_ref_clk,
    input wire logic            i_resetn,
    input wire logic            i_cs_n,
    input wire logic            i_guard_n,
    input wire logic            o_so_oe,
    input wire ssp_status_t     o_status,
    input wire logic            o_busy,
    input wire logic            o_array_allowed
);
    int unsigned busy_cnt;
    always_ff @(posedge i_ref_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= o_busy ? busy_cnt + 1 : 0;
        end
    end
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    chk_busy_bounded: assert property (busy_cnt <= WC_COUNT + 2)
        else $error("busy held too long");
    chk_busy_full: assert property ($fell(o_busy) |-> busy_cnt + 2 >= WC_COUNT)
        else $error("busy ended early");
    chk_busy_hold: assert property ($rose(o_busy) |=> o_busy [*8])
        else $error("busy dropped at once");
    chk_latch_end: assert property ($fell(o_busy) |-> ##[0:1] !o_status.write_latch)
        else $error("latch kept after cycle");
    chk_start_latch: assert property ($rose(o_busy) |-> $past(o_status.write_latch))
        else $error("cycle without latch");
    chk_guard_block: assert property ($rose(o_busy) |->
        !$past(o_status.guard_pin_enable) || $past(i_guard_n, 4))
        else $error("cycle under guard");
    chk_latch_frozen: assert property (o_busy && $past(o_busy) |->
        $stable(o_status.write_latch))
        else $error("latch moved while busy");
    chk_nv_at_end: assert property ($changed({o_status.guard_pin_enable, o_status.block_level})
        |-> $past(o_busy) || $past(o_busy, 2) || !$past(i_resetn, 2))
        else $error("stored bits changed outside cycle");
    chk_full_protect: assert property (o_status.block_level == 2'h3 &&
        $past(o_status.block_level) == 2'h3 |-> !o_array_allowed)
        else $error("array allowed at full level");
    chk_oe_idle: assert property (i_cs_n [*6] |-> !o_so_oe)
        else $error("so driven while deselected");
endmodule : ssp_core_checker

bind ssp_core ssp_core_checker #(.WC_COUNT(WC_COUNT)) ssp_core_checker_i (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_guard_n(i_guard_n),
    .o_so_oe(o_so_oe), .o_status(o_status), .o_busy(o_busy),
    .o_array_allowed(o_array_allowed));

/* sim/ssp_spi_master.sv */
module ssp_spi_master (
    output logic      o_cs_n,
    output logic      o_sck,
    output logic      o_si,
    input  wire logic i_so
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        o_cs_n = 1'b1;
        o_sck = 1'b0;
        o_si = 1'b0;
    end
    // mode 0 frame, msb first, clock still outside frames
    task automatic xfer(input logic [31:0] bits, input int n, output logic [7:0] rx);
        rx = 8'h00;
        o_cs_n = 1'b0;
        #250;
        for (int k = 31; k > 31 - n; k--) begin
            o_si = bits[k];
            #62.5;
            o_sck = 1'b1;
            rx = {rx[6:0], i_so};
            #62.5;
            o_sck = 1'b0;
        end
        #250;
        o_cs_n = 1'b1;
        o_si = ~o_si;
        #500;
    endtask : xfer
endmodule : ssp_spi_master

/* sim/ssp_core_tb.sv */
module ssp_core_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ssp_pkg::*;
    localparam int  WC = 1000;
    logic           i_ref_clk = 1'b0;
    logic           i_resetn = 1'b0;
    logic           i_guard_n = 1'b1;
    logic           junk = 1'b0;
    logic           cs_n, sck, si, so_w, o_so, o_so_oe, o_busy, o_array_allowed;
    logic [7:0]     rx;
    bit             busy_seen;
    bit             req_seen;
    logic [14:0]    req_addr;
    int             num_errors, check_count;
    ssp_status_t    o_status;
    ssp_array_req_t o_array_req;
    always #5 i_ref_clk = ~i_ref_clk;
    always @(posedge i_ref_clk) begin
        junk <= ~junk;
        if (o_busy === 1'b1) busy_seen = 1'b1;
        if (o_array_req.write_req === 1'b1) begin
            req_seen = 1'b1;
            req_addr = o_array_req.addr;
        end
    end
    assign so_w = o_so_oe ? o_so : junk;
    ssp_core #(.WC_COUNT(WC)) ssp_core_i (.i_ref_clk(i_ref_clk), .i_resetn(i_resetn),
        .i_cs_n(cs_n), .i_sck(sck), .i_si(si), .i_guard_n(i_guard_n),
        .i_nv_bits_level(2'h1), .i_nv_bits_enable(1'b0), .o_so(o_so), .o_so_oe(o_so_oe),
        .o_status(o_status), .o_busy(o_busy), .o_array_req(o_array_req),
        .o_array_allowed(o_array_allowed));
    ssp_spi_master ssp_spi_master_i (.o_cs_n(cs_n), .o_sck(sck), .o_si(si), .i_so(so_w));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic frame(input logic [7:0] op, input logic [7:0] d, input int n);
        ssp_spi_master_i.xfer({op, d, 16'h0}, n, rx);
    endtask : frame
    task automatic frame_arr(input logic [15:0] a, input logic [7:0] d);
        ssp_spi_master_i.xfer({8'h02, a, d}, 32, rx);
    endtask : frame_arr
    task automatic set_guard(input logic v);
        @(posedge i_ref_clk);
        #1 i_guard_n = v;
    endtask : set_guard
    task automatic wait_idle;
        for (int k = 0; k < WC + 200 && o_busy !== 1'b0; k++) @(posedge i_ref_clk);
        if (o_busy !== 1'b0) num_errors++;
    endtask : wait_idle
    task automatic t_power_up;
        frame(8'h05, 8'h00, 16);
        check(rx, 8'h04);
        check({4'h0, o_status}, 8'h01);
    endtask : t_power_up
    task automatic t_latch_cmds;
        frame(8'h0E, 8'h00, 8);
        frame(8'h0D, 8'h00, 16);
        check(rx, 8'h06);
        set_guard(1'b0);
        frame(8'h04, 8'h00, 8);
        frame(8'h16, 8'h00, 8);
        frame(8'h05, 8'h00, 16);
        check(rx, 8'h04);
        set_guard(1'b1);
    endtask : t_latch_cmds
    task automatic t_status_write;
        busy_seen = 1'b0;
        frame(8'h01, 8'hFF, 16);
        check({7'h0, busy_seen}, 8'h00);
        frame(8'h06, 8'h00, 8);
        frame(8'h01, 8'hFF, 16);
        frame(8'h05, 8'h00, 16);
        check(rx, 8'h77);
        frame(8'h04, 8'h00, 8);
        check({7'h0, o_status.write_latch}, 8'h01);
        wait_idle();
        frame(8'h05, 8'h00, 16);
        check(rx, 8'h8C);
    endtask : t_status_write
    task automatic t_guard;
        set_guard(1'b0);
        frame(8'h06, 8'h00, 8);
        busy_seen = 1'b0;
        frame(8'h01, 8'h00, 16);
        check({7'h0, busy_seen}, 8'h00);
        check({7'h0, o_array_allowed}, 8'h00);
        set_guard(1'b1);
        frame(8'h06, 8'h00, 8);
        fork
            frame(8'h01, 8'h04, 16);
            begin #1200; set_guard(1'b0); end
        join
        check({7'h0, busy_seen}, 8'h00);
        set_guard(1'b1);
        frame(8'h06, 8'h00, 8);
        fork
            frame(8'h01, 8'h04, 16);
            begin #2300; set_guard(1'b0); end
        join
        check({7'h0, busy_seen}, 8'h00);
        set_guard(1'b1);
        frame(8'h06, 8'h00, 8);
        frame(8'h01, 8'h04, 16);
        set_guard(1'b0);
        wait_idle();
        frame(8'h05, 8'h00, 16);
        check(rx, 8'h04);
        frame(8'h06, 8'h00, 8);
        frame(8'h01, 8'h08, 16);
        wait_idle();
        frame(8'h05, 8'h00, 16);
        check(rx, 8'h08);
    endtask : t_guard
    task automatic t_array;
        req_seen = 1'b0;
        frame_arr(16'h1000, 8'hA5);
        check({7'h0, req_seen}, 8'h00);
        frame(8'h06, 8'h00, 8);
        frame_arr(16'h7000, 8'hA5);
        check({7'h0, req_seen}, 8'h00);
        frame_arr(16'h1000, 8'h5A);
        check({7'h0, req_seen}, 8'h01);
        check({1'b0, req_addr[14:8]}, 8'h10);
        check({7'h0, o_array_allowed}, 8'h01);
    endtask : t_array
    task automatic conclude;
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (20) @(posedge i_ref_clk);
        #1 i_resetn = 1'b1;
        repeat (5) @(posedge i_ref_clk);
        t_power_up();
        t_latch_cmds();
        t_status_write();
        t_guard();
        t_array();
        conclude();
    end
    initial begin
        #400us;
        num_errors++;
        conclude();
    end
endmodule : ssp_core_tb
